// >>> hw/ipc_irq_priority.sv
`timescale 1ns/100ps
module ipc_irq_priority
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire logic [23:0] periph_pend,
    input wire logic [3:0] ext_pin,
    input wire logic [3:0] portb_upper,
    input wire logic [1:0] can_mode,
    input wire logic micro_mode,
    // Reset causes
    input wire logic reset_instr_event,
    input wire logic power_on_event,
    input wire logic brownout_event,
    input wire logic watchdog_expiry_flag,
    input wire logic power_down_flag,
    // CPU core
    input wire logic core_sleeping,
    input wire logic irq_take,
    input wire logic irq_take_high,
    input wire logic [PC_W-1:0] take_pc,
    input wire ipc_ctx_t take_ctx,
    input wire logic ret_pop,
    output logic irq_high,
    output logic irq_low,
    output logic wake,
    output logic [PC_W-1:0] ret_pc,
    output ipc_ctx_t ret_ctx,
    output logic stack_full,
    output logic stack_empty
);

    logic [7:0] prio_one;
    logic [7:0] prio_two;
    logic [7:0] prio_three;
    logic [7:0] reset_ctrl;
    logic [7:0] irq_control_reg;
    logic [7:0] irq_control_reg_two;
    logic [7:0] irq_control_reg_three;
    logic [7:0] tmr0_ctrl;
    logic [15:0] tmr0_count;
    logic [3:0] ext_prev;
    logic [3:0] portb_prev;
    logic hist_valid;

    logic [23:0] avail;
    logic [23:0] prio_eff;
    logic [23:0] periph_ok;
    logic [3:0] ext_edge;
    logic [3:0] ext_irq_flag;
    logic [3:0] ext_irq_enable;
    logic portb_change;
    logic tmr0_wrap;
    logic [5:0] core_pend;
    logic [5:0] core_prio;
    logic priority_levels_enable;
    logic bus_take;
    logic bus_wr;
    logic addr_ok;
    logic [31:0] rd_word;
    logic next_high;
    logic next_low;

    // Which peripheral priority bits exist for the current mode
    function automatic logic [23:0] avail_mask(input logic micro, input logic [1:0] mode);
        logic [7:0] m1;
        logic [7:0] m3;
        m1 = 8'hFF;
        m3 = 8'hFF;
        m1[P1_SLAVE_PORT] = micro;
        if (mode != CAN_MODE_ZERO) begin
            m3[P3_TXB1] = 1'b0;
            m3[P3_TXB0] = 1'b0;
        end
        if (mode == CAN_MODE_ONE) begin
            m3[P3_RXB0] = 1'b0;
        end
        return {m3, PRIO_TWO_MASK, m1};
    endfunction : avail_mask

    function automatic logic addr_hit(input logic [7:0] a);
        return (a == ADDR_PRIO_ONE) || (a == ADDR_PRIO_TWO) || (a == ADDR_PRIO_THREE)
            || (a == ADDR_RESET_CTRL) || (a == ADDR_IRQ_CTL) || (a == ADDR_IRQ_CTL_TWO)
            || (a == ADDR_IRQ_CTL_THREE) || (a == ADDR_TMR0_CTRL)
            || (a == ADDR_TMR0_COUNT);
    endfunction : addr_hit

    assign priority_levels_enable = reset_ctrl[RC_PRIO_EN];
    // Bit 7 of register one follows micro_mode; bits 3, 2 and 0 of register three depend on the CAN mode
    assign avail = avail_mask(micro_mode, can_mode);
    assign prio_eff = {prio_three, prio_two, prio_one} & avail;
    assign periph_ok = periph_pend & avail;

    // Bus handshake: one wait state, answer at the edge after the first access cycle
    assign bus_take = psel && penable && !pready;
    assign bus_wr = psel && penable && pready && pwrite;
    assign addr_ok = addr_hit(paddr);

    // External pin edge detection
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ext
            logic sel;
            assign sel = irq_control_reg_two[CTL2_EDGE_TOP - gi];
            assign ext_edge[gi] = hist_valid && (sel ? (ext_pin[gi] && !ext_prev[gi])
                                      : (!ext_pin[gi] && ext_prev[gi]));
        end
    endgenerate

    assign ext_irq_flag = {irq_control_reg_three[CTL3_FLAG_BASE +: 3],
                           irq_control_reg[CTL_EXT0_FLAG]};
    assign ext_irq_enable = {irq_control_reg_three[CTL3_EN_BASE +: 3],
                             irq_control_reg[CTL_EXT0_EN]};

    assign portb_change = hist_valid && (|(portb_upper ^ portb_prev));

    assign tmr0_wrap = tmr0_ctrl[T0_ON] && (tmr0_ctrl[T0_EIGHT_BIT]
        ? (tmr0_count[7:0] == T0_LOW_MAX) : (tmr0_count == T0_FULL_MAX));

    // Core sources: timer0, ext0, port-B change, ext1, ext2, ext3
    assign core_pend = {
        ext_irq_enable[3:1] & ext_irq_flag[3:1],
        irq_control_reg[CTL_RB_EN] && irq_control_reg[CTL_RB_FLAG],
        irq_control_reg[CTL_EXT0_EN] && irq_control_reg[CTL_EXT0_FLAG],
        irq_control_reg[CTL_TMR0_EN] && irq_control_reg[CTL_TMR0_FLAG]
    };
    assign core_prio = {
        irq_control_reg_two[CTL2_EXT3_PRIO],
        irq_control_reg_three[CTL3_EXT2_PRIO],
        irq_control_reg_three[CTL3_EXT1_PRIO],
        irq_control_reg_two[CTL2_RB_PRIO],
        1'b1,
        irq_control_reg_two[CTL2_TMR0_PRIO]
    };

    // Vector routing
    always_comb begin
        if (priority_levels_enable) begin
            next_high = irq_control_reg[CTL_GLOBAL_EN]
                && ((|(core_pend & core_prio)) || (|(periph_ok & prio_eff)));
            next_low = irq_control_reg[CTL_PERIPH_EN]
                && ((|(core_pend & ~core_prio)) || (|(periph_ok & ~prio_eff)));
        end else begin
            next_high = irq_control_reg[CTL_GLOBAL_EN] && ((|core_pend)
                || (irq_control_reg[CTL_PERIPH_EN] && (|periph_ok)));
            next_low = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq_high <= next_high;
            irq_low <= next_low;
            wake <= core_sleeping && (|(ext_irq_enable & ext_irq_flag));
        end
    end

    // Input history; no edge is seen before the first real sample
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev <= 4'h0;
            portb_prev <= 4'h0;
            hist_valid <= 1'b0;
        end else begin
            ext_prev <= ext_pin;
            portb_prev <= portb_upper;
            hist_valid <= 1'b1;
        end
    end

    // Peripheral priority registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prio_one <= PRIO_ONE_RST;
            prio_two <= PRIO_TWO_RST;
            prio_three <= PRIO_THREE_RST;
        end else if (bus_wr) begin
            if (paddr == ADDR_PRIO_ONE) begin
                prio_one <= pwdata[7:0];
            end
            if (paddr == ADDR_PRIO_TWO) begin
                prio_two <= pwdata[7:0] & PRIO_TWO_MASK;
            end
            if (paddr == ADDR_PRIO_THREE) begin
                prio_three <= pwdata[7:0];
            end
        end
    end

    // Reset control: hardware cause events win over a software clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reset_ctrl <= RESET_CTRL_RST;
        end else begin
            if (bus_wr && (paddr == ADDR_RESET_CTRL)) begin
                reset_ctrl[RC_PRIO_EN] <= pwdata[RC_PRIO_EN];
                reset_ctrl[RC_RESET_INSTR] <= pwdata[RC_RESET_INSTR] || reset_instr_event;
                reset_ctrl[RC_POWER_ON] <= pwdata[RC_POWER_ON] || power_on_event;
                reset_ctrl[RC_BROWNOUT] <= pwdata[RC_BROWNOUT] || brownout_event;
            end else begin
                reset_ctrl[RC_RESET_INSTR] <= reset_ctrl[RC_RESET_INSTR] || reset_instr_event;
                reset_ctrl[RC_POWER_ON] <= reset_ctrl[RC_POWER_ON] || power_on_event;
                reset_ctrl[RC_BROWNOUT] <= reset_ctrl[RC_BROWNOUT] || brownout_event;
            end
            reset_ctrl[RC_WATCHDOG] <= watchdog_expiry_flag;
            reset_ctrl[RC_POWER_DOWN] <= power_down_flag;
        end
    end

    // Interrupt control: flags set by hardware, cleared only by software
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_control_reg <= IRQ_CTL_RST;
        end else begin
            logic [7:0] v;
            v = irq_control_reg;
            if (bus_wr && (paddr == ADDR_IRQ_CTL)) begin
                v = pwdata[7:0];
            end
            if (irq_take) begin
                if (priority_levels_enable && !irq_take_high) begin
                    v[CTL_PERIPH_EN] = 1'b0;
                end else begin
                    v[CTL_GLOBAL_EN] = 1'b0;
                end
            end
            v[CTL_TMR0_FLAG] = v[CTL_TMR0_FLAG] || tmr0_wrap;
            v[CTL_EXT0_FLAG] = v[CTL_EXT0_FLAG] || ext_edge[0];
            v[CTL_RB_FLAG] = v[CTL_RB_FLAG] || portb_change;
            irq_control_reg <= v;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_control_reg_two <= IRQ_CTL_TWO_RST;
        end else if (bus_wr && (paddr == ADDR_IRQ_CTL_TWO)) begin
            irq_control_reg_two <= pwdata[7:0] & IRQ_CTL_TWO_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_control_reg_three <= IRQ_CTL_THREE_RST;
        end else begin
            logic [7:0] v;
            v = irq_control_reg_three;
            if (bus_wr && (paddr == ADDR_IRQ_CTL_THREE)) begin
                v = pwdata[7:0];
            end
            v[CTL3_FLAG_BASE +: 3] = v[CTL3_FLAG_BASE +: 3] | ext_edge[3:1];
            irq_control_reg_three <= v;
        end
    end

    // Timer0: low byte only counts in 8-bit mode
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tmr0_ctrl <= TMR0_CTRL_RST;
        end else if (bus_wr && (paddr == ADDR_TMR0_CTRL)) begin
            tmr0_ctrl <= pwdata[7:0] & TMR0_CTRL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tmr0_count <= TMR0_COUNT_RST;
        end else if (bus_wr && (paddr == ADDR_TMR0_COUNT)) begin
            tmr0_count <= pwdata[15:0];
        end else if (tmr0_ctrl[T0_ON]) begin
            if (tmr0_ctrl[T0_EIGHT_BIT]) begin
                tmr0_count[7:0] <= tmr0_count[7:0] + 8'h01;
            end else begin
                tmr0_count <= tmr0_count + 16'h0001;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            ADDR_PRIO_ONE: rd_word[7:0] = prio_eff[7:0];
            ADDR_PRIO_TWO: rd_word[7:0] = prio_eff[15:8];
            ADDR_PRIO_THREE: rd_word[7:0] = prio_eff[23:16];
            ADDR_RESET_CTRL: rd_word[7:0] = reset_ctrl & RESET_CTRL_MASK;
            ADDR_IRQ_CTL: rd_word[7:0] = irq_control_reg;
            ADDR_IRQ_CTL_TWO: rd_word[7:0] = irq_control_reg_two;
            ADDR_IRQ_CTL_THREE: rd_word[7:0] = irq_control_reg_three;
            ADDR_TMR0_CTRL: rd_word[7:0] = tmr0_ctrl;
            ADDR_TMR0_COUNT: rd_word[15:0] = tmr0_count;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= bus_take;
            pslverr <= bus_take && !addr_ok;
            if (bus_take && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // Fast context saved on entry
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ret_ctx <= '0;
        end else if (irq_take) begin
            ret_ctx <= take_ctx;
        end
    end

    ipc_stack u_stack (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .push(irq_take),
        .push_data(take_pc),
        .pop(ret_pop),
        .pop_data(ret_pc),
        .full(stack_full),
        .empty(stack_empty)
    );

endmodule : ipc_irq_priority

// >>> hw/ipc_pkg.sv
package ipc_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_PRIO_ONE = 8'h00;
    localparam logic [7:0] ADDR_PRIO_TWO = 8'h04;
    localparam logic [7:0] ADDR_PRIO_THREE = 8'h08;
    localparam logic [7:0] ADDR_RESET_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_CTL = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CTL_TWO = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CTL_THREE = 8'h18;
    localparam logic [7:0] ADDR_TMR0_CTRL = 8'h1C;
    localparam logic [7:0] ADDR_TMR0_COUNT = 8'h20;

    // Reset values and implemented-bit masks
    localparam logic [7:0] PRIO_ONE_RST = 8'hFF;
    localparam logic [7:0] PRIO_TWO_RST = 8'h5F;
    localparam logic [7:0] PRIO_TWO_MASK = 8'h5F;
    localparam logic [7:0] PRIO_THREE_RST = 8'hFF;
    localparam logic [7:0] RESET_CTRL_RST = 8'h1C;
    localparam logic [7:0] RESET_CTRL_MASK = 8'h9F;
    localparam logic [7:0] IRQ_CTL_RST = 8'h00;
    localparam logic [7:0] IRQ_CTL_TWO_RST = 8'h7F;
    localparam logic [7:0] IRQ_CTL_TWO_MASK = 8'h7F;
    localparam logic [7:0] IRQ_CTL_THREE_RST = 8'hC0;
    localparam logic [7:0] TMR0_CTRL_RST = 8'h40;
    localparam logic [7:0] TMR0_CTRL_MASK = 8'hC0;
    localparam logic [15:0] TMR0_COUNT_RST = 16'h0000;

    // Reset control fields
    localparam int RC_PRIO_EN = 7;
    localparam int RC_RESET_INSTR = 4;
    localparam int RC_WATCHDOG = 3;
    localparam int RC_POWER_DOWN = 2;
    localparam int RC_POWER_ON = 1;
    localparam int RC_BROWNOUT = 0;

    // Interrupt control fields
    localparam int CTL_GLOBAL_EN = 7;
    localparam int CTL_PERIPH_EN = 6;
    localparam int CTL_TMR0_EN = 5;
    localparam int CTL_EXT0_EN = 4;
    localparam int CTL_RB_EN = 3;
    localparam int CTL_TMR0_FLAG = 2;
    localparam int CTL_EXT0_FLAG = 1;
    localparam int CTL_RB_FLAG = 0;

    // Interrupt control two: edge select of ext i at CTL2_EDGE_TOP - i
    localparam int CTL2_EDGE_TOP = 6;
    localparam int CTL2_TMR0_PRIO = 2;
    localparam int CTL2_EXT3_PRIO = 1;
    localparam int CTL2_RB_PRIO = 0;

    // Interrupt control three: enable of ext i at base + i - 1
    localparam int CTL3_EXT2_PRIO = 7;
    localparam int CTL3_EXT1_PRIO = 6;
    localparam int CTL3_EN_BASE = 3;
    localparam int CTL3_FLAG_BASE = 0;

    // Peripheral priority special bits
    localparam int P1_SLAVE_PORT = 7;
    localparam int P3_TXB1 = 3;
    localparam int P3_TXB0 = 2;
    localparam int P3_RXB0 = 0;

    // Timer0 control fields
    localparam int T0_ON = 7;
    localparam int T0_EIGHT_BIT = 6;
    localparam logic [7:0] T0_LOW_MAX = 8'hFF;
    localparam logic [15:0] T0_FULL_MAX = 16'hFFFF;

    // CAN operating modes
    localparam logic [1:0] CAN_MODE_ZERO = 2'h0;
    localparam logic [1:0] CAN_MODE_ONE = 2'h1;

    // Stacks
    localparam int PC_W = 21;
    localparam int STACK_DEPTH = 31;
    localparam int PTR_W = 5;

    typedef struct packed {
        logic [7:0] working_register;
        logic [7:0] status;
        logic [7:0] bank_select_register;
    } ipc_ctx_t;

endpackage : ipc_pkg

// >>> hw/ipc_stack.sv
`timescale 1ns/100ps
module ipc_stack
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Push and pop
    input wire logic push,
    input wire logic [PC_W-1:0] push_data,
    input wire logic pop,
    output logic [PC_W-1:0] pop_data,
    // Occupancy
    output logic full,
    output logic empty
);

    localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(STACK_DEPTH);
    localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;

    logic [PC_W-1:0] mem [STACK_DEPTH];
    logic [PTR_W-1:0] ptr;
    logic [PTR_W-1:0] next_ptr;
    logic do_push;
    logic do_pop;

    // Push beyond the top and pop of an empty stack are dropped
    assign do_push = push && (ptr != PTR_MAX);
    assign do_pop = pop && !push && (ptr != '0);

    always_comb begin
        next_ptr = ptr;
        if (do_push) begin
            next_ptr = ptr + PTR_ONE;
        end else if (do_pop) begin
            next_ptr = ptr - PTR_ONE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[ptr] <= push_data;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ptr <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else begin
            ptr <= next_ptr;
            full <= (next_ptr == PTR_MAX);
            empty <= (next_ptr == '0);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pop_data <= '0;
        end else if (do_pop) begin
            pop_data <= mem[ptr - PTR_ONE];
        end
    end

endmodule : ipc_stack

// >>> dv/ipc_irq_priority_properties.sv
`timescale 1ns/100ps
module ipc_chk
    import ipc_pkg::*;
(
    // Clock, reset and bus
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Modes and core
    input wire logic [1:0] can_mode,
    input wire logic micro_mode,
    input wire logic irq_take,
    input wire logic irq_take_high,
    input wire logic [PC_W-1:0] take_pc,
    input wire logic ret_pop,
    input wire logic [PC_W-1:0] ret_pc,
    input wire ipc_ctx_t take_ctx,
    input wire logic irq_high,
    input wire logic irq_low,
    input wire ipc_ctx_t ret_ctx,
    input wire logic stack_full,
    input wire logic stack_empty
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic prio_en;
    wire logic rd = pready && !pwrite;
    // Shadow of the priority levels enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prio_en <= 1'h0;
        end else if (psel && penable && pready && pwrite && paddr == ADDR_RESET_CTRL) begin
            prio_en <= pwdata[RC_PRIO_EN];
        end
    end
    property p_two_rsvd;
        (rd && paddr == ADDR_PRIO_TWO) |-> !prdata[7] && !prdata[5];
    endproperty
    a_two_rsvd: assert property (p_two_rsvd) else $error("prio two reserved");
    property p_rc_rsvd;
        (rd && paddr == ADDR_RESET_CTRL) |-> prdata[6:5] == 2'h0;
    endproperty
    a_rc_rsvd: assert property (p_rc_rsvd) else $error("reset ctrl reserved");
    property p_slave;
        !micro_mode [*3] ##0 (rd && paddr == ADDR_PRIO_ONE) |-> !prdata[P1_SLAVE_PORT];
    endproperty
    a_slave: assert property (p_slave) else $error("slave port bit");
    property p_tx_forced;
        (can_mode != CAN_MODE_ZERO) [*3] ##0 (rd && paddr == ADDR_PRIO_THREE)
            |-> prdata[P3_TXB1:P3_TXB0] == 2'h0;
    endproperty
    a_tx_forced: assert property (p_tx_forced) else $error("tx bits not forced");
    property p_legacy_low;
        !prio_en [*2] |-> !irq_low;
    endproperty
    a_legacy_low: assert property (p_legacy_low) else $error("low in legacy");
    property p_ctx;
        irq_take |=> ret_ctx == $past(take_ctx);
    endproperty
    a_ctx: assert property (p_ctx) else $error("context not saved");
    property p_push;
        irq_take && !stack_full |=> !stack_empty;
    endproperty
    a_push: assert property (p_push) else $error("return not pushed");
    property p_ret;
        irq_take && !stack_full ##1 (ret_pop && !irq_take) |=> ret_pc == $past(take_pc, 2);
    endproperty
    a_ret: assert property (p_ret) else $error("return address lost");
    property p_gie_clear;
        irq_take && irq_take_high |-> ##2 !irq_high;
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("high stays");
    c_high: cover property (irq_take && irq_take_high);
    c_low: cover property (irq_take && !irq_take_high);
    c_low_req: cover property (irq_low && prio_en);
endmodule : ipc_chk
bind ipc_irq_priority ipc_chk ipc_chk_inst (.ref_clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .can_mode, .micro_mode, .irq_take, .irq_take_high,
    .take_pc, .ret_pop, .ret_pc, .take_ctx, .irq_high, .irq_low, .ret_ctx, .stack_full,
    .stack_empty);

// >>> dv/ipc_core_model.sv
`timescale 1ns/100ps
module ipc_core_model
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Core side
    input wire logic take_en,
    input wire logic irq_high,
    input wire logic irq_low,
    output logic irq_take,
    output logic irq_take_high,
    output logic [PC_W-1:0] take_pc,
    output ipc_ctx_t take_ctx,
    output logic ret_pop
);
    // Takes one request, returns at once; guard only while irq_take or ret_pop is high, not until the request drops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_take <= 1'h0;
            irq_take_high <= 1'h0;
            take_pc <= '0;
            take_ctx <= '0;
            ret_pop <= 1'h0;
        end else begin
            irq_take <= take_en && !irq_take && !ret_pop && (irq_high || irq_low);
            irq_take_high <= irq_high;
            take_pc <= take_pc + PC_W'(1);
            take_ctx <= ipc_ctx_t'(24'($urandom));
            ret_pop <= irq_take;
        end
    end
endmodule : ipc_core_model

// >>> dv/ipc_irq_priority_tb_top.sv
`timescale 1ns/100ps
module ipc_irq_priority_tb_top
    import ipc_pkg::*;
;
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, micro_mode = 1;
    logic power_on_event = 0, brownout_event = 0, core_sleeping = 0, take_en = 0, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, q, d, prdata;
    logic [23:0] periph_pend = 0;
    logic [3:0] ext_pin = 0, portb_upper = 0, e, x;
    logic [1:0] can_mode = 0;
    logic pready, pslverr, irq_high, irq_low, wake, irq_take, irq_take_high, ret_pop;
    logic stack_full, stack_empty;
    logic [PC_W-1:0] take_pc, ret_pc;
    ipc_ctx_t take_ctx, ret_ctx;
    logic [31:0] tq[$];
    int failures = 0, n_tests = 0;
    ipc_irq_priority ipc_irq_priority_inst (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .periph_pend, .ext_pin, .portb_upper, .can_mode,
        .micro_mode, .reset_instr_event(1'h0), .power_on_event, .brownout_event,
        .watchdog_expiry_flag(1'h1), .power_down_flag(1'h1), .core_sleeping, .irq_take,
        .irq_take_high, .take_pc, .take_ctx, .ret_pop, .irq_high, .irq_low, .wake, .ret_pc,
        .ret_ctx, .stack_full, .stack_empty);
    ipc_core_model ipc_core_model_inst (.ref_clk, .nrst, .take_en, .irq_high, .irq_low,
        .irq_take, .irq_take_high, .take_pc, .take_ctx, .ret_pop);
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] xv, input logic [31:0] s);
        n_tests++;
        if (s !== xv) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, xv, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, dv};
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] xv, input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, xv, q);
    endtask : rd
    task automatic irqs(input logic [1:0] xv, input string nm);
        repeat (2) @(posedge ref_clk);
        chk(nm, {30'h0, xv}, {30'h0, irq_high, irq_low});
    endtask : irqs
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        results();
    end
    initial begin
        void'($urandom(32'hA1C880AD));
        repeat (20) @(posedge ref_clk);
        nrst <= 1'h1;
        rd(ADDR_PRIO_ONE, 32'hFF, "prio_one");
        rd(ADDR_PRIO_TWO, 32'h5F, "prio_two");
        rd(ADDR_PRIO_THREE, 32'hFF, "prio_three");
        rd(ADDR_RESET_CTRL, 32'h1C, "reset_ctrl");
        d = $urandom;
        apb(1'h1, ADDR_PRIO_ONE, d);
        apb(1'h1, ADDR_PRIO_TWO, d);
        rd(ADDR_PRIO_ONE, {24'h0, d[7:0]}, "prio_one_rw");
        rd(ADDR_PRIO_TWO, {24'h0, d[7:0] & 8'h5F}, "prio_two_rw");
        apb(1'h1, ADDR_PRIO_ONE, 32'hFF);
        for (int m = 0; m < 3; m++) begin
            can_mode <= m[1:0];
            micro_mode <= !m[0];
            rd(ADDR_PRIO_THREE, m == 0 ? 32'hFF : m == 1 ? 32'hF2 : 32'hF3, "mode");
            rd(ADDR_PRIO_ONE, m == 1 ? 32'h7F : 32'hFF, "slave_port");
        end
        can_mode <= 2'h0;
        apb(1'h0, 8'h3C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        {power_on_event, brownout_event} <= 2'h3;
        @(posedge ref_clk);
        {power_on_event, brownout_event} <= 2'h0;
        rd(ADDR_RESET_CTRL, 32'h1F, "reset_cause");
        $display("test registers done");
        e = 4'($urandom);
        ext_pin <= ~e;
        apb(1'h1, ADDR_IRQ_CTL_TWO, {25'h0, e[0], e[1], e[2], e[3], 3'h7});
        apb(1'h1, ADDR_IRQ_CTL, 32'h10);
        apb(1'h1, ADDR_IRQ_CTL_THREE, 32'hF8);
        core_sleeping <= 1'h1;
        x = 4'h0;
        for (int i = 0; i < 4; i++) begin
            ext_pin[i] <= e[i];
            @(posedge ref_clk);
            ext_pin[i] <= ~e[i];
            x[i] = 1'h1;
            apb(1'h0, ADDR_IRQ_CTL, 32'h0);
            chk("ext0_flag", {31'h0, x[0]}, {31'h0, q[CTL_EXT0_FLAG]});
            rd(ADDR_IRQ_CTL_THREE, {24'h0, 5'h1F, x[3:1]}, "ext_flags");
            chk("wake", 32'h1, {31'h0, wake});
        end
        apb(1'h1, ADDR_IRQ_CTL, 32'h0);
        apb(1'h1, ADDR_IRQ_CTL_THREE, 32'hC7);
        repeat (2) @(posedge ref_clk);
        chk("wake_masked", 32'h0, {31'h0, wake});
        core_sleeping <= 1'h0;
        apb(1'h1, ADDR_IRQ_CTL_THREE, 32'hC0);
        $display("test external done");
        periph_pend <= 24'h1;
        apb(1'h1, ADDR_PRIO_ONE, 32'h0);
        apb(1'h1, ADDR_IRQ_CTL, 32'h80);
        irqs(2'h0, "no_peripheral_irq_global_enable");
        apb(1'h1, ADDR_IRQ_CTL, 32'hC0);
        irqs(2'h2, "legacy");
        apb(1'h1, ADDR_RESET_CTRL, 32'h80);
        irqs(2'h1, "prio_low");
        apb(1'h1, ADDR_PRIO_ONE, 32'h1);
        irqs(2'h2, "prio_high");
        periph_pend <= 24'h0;
        apb(1'h1, ADDR_IRQ_CTL, 32'hD2);
        irqs(2'h2, "ext0_high");
        periph_pend <= 24'h1;
        take_en <= 1'h1;
        for (int h = 1; h >= 0; h--) begin
            apb(1'h1, ADDR_PRIO_ONE, h);
            apb(1'h1, ADDR_IRQ_CTL, 32'hC0);
            repeat (8) @(posedge ref_clk);
            rd(ADDR_IRQ_CTL, h ? 32'h40 : 32'h80, "entry");
            chk("stack_empty", 32'h1, {31'h0, stack_empty});
        end
        {take_en, periph_pend} <= 25'h0;
        apb(1'h1, ADDR_RESET_CTRL, 32'h0);
        $display("test routing done");
        tq = '{32'hC000F0, 32'h8000F0, 32'h80FFF0};
        foreach (tq[j]) begin
            apb(1'h1, ADDR_TMR0_CTRL, 32'h0);
            apb(1'h1, ADDR_IRQ_CTL, 32'h0);
            apb(1'h1, ADDR_TMR0_COUNT, {16'h0, tq[j][15:0]});
            apb(1'h1, ADDR_TMR0_CTRL, {24'h0, tq[j][23:16]});
            repeat (30) @(posedge ref_clk);
            rd(ADDR_IRQ_CTL, j == 1 ? 32'h0 : 32'h4, "timer_flag");
        end
        apb(1'h1, ADDR_TMR0_CTRL, 32'h0);
        apb(1'h1, ADDR_IRQ_CTL, 32'h0);
        portb_upper <= portb_upper ^ 4'(1 + $urandom % 15);
        rd(ADDR_IRQ_CTL, 32'h1, "portb_change");
        $display("test timer and port done");
        results();
    end
endmodule : ipc_irq_priority_tb_top
